// ===== hw/amc_mode_ctrl.sv
// operating-mode controller of a sigma-delta converter
// assumes host writes arrive as clean same-clock strobes; modulator results arrive as pulses
//
// Functional notes
// - mode 0000 is continuous conversion, default after reset, results stored each time
// - ready output goes low each time a continuous conversion completes
// - continuous read shifts results out; otherwise host requests them by command
// - first result only after full settling; later results at output data rate
// - mode 0001 converts once with full settling, stores, asserts ready, enters standby
// - single result and low ready stay until read or next conversion; ready also returns high on any control write
// - mode 0010 standby: only regulators forced on; four circuits stay enableable
// - register contents are kept in standby
// - enabled diagnostics stay active when idle; enables writable in standby
// - clock-based diagnostics do not work if enabled during standby
// - mode 0011 powers everything down, regulators included
// - enable and data registers lost in power-down, control register kept; host must reprogram them
// - mode field is bits 5 to 2 of the control register
// - mode 0100 holds filter and modulator in reset, clocks running
// - completing a data read returns ready high
`timescale 1ns/1ps
`include "amc_defines.svh"
module amc_mode_ctrl
   import amc_pkg::*;
#(
   parameter int SETTLE_CYCLES = `AMC_SETTLE_DEFAULT,
   parameter int RATE_CYCLES   = `AMC_RATE_DEFAULT
)(
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_ctrl_we,
   input  wire logic [15:0] i_ctrl_wdata,
   input  wire logic        i_diag_we,
   input  wire logic        i_diag_en,
   input  wire logic [3:0]  i_circ_en,
   input  wire logic        i_cont_read,
   input  wire logic        i_read_cmd,
   input  wire logic        i_data_read_done,
   input  wire logic        i_sample_valid,
   input  wire logic [23:0] i_sample,
   output logic [15:0]      o_ctrl,
   output logic [23:0]      o_data,
   output logic             o_ready_n,
   output logic             o_shift_out,
   output logic [3:0]       o_mode,
   output amc_power_t       o_power
);

   // ***********************************************************
   // elaboration checks
   // ***********************************************************
   // counts outside the 16-bit counter are refused before anything runs
   if (SETTLE_CYCLES < 1 || RATE_CYCLES < 1 || SETTLE_CYCLES > 65535 || RATE_CYCLES > 65535)
   begin
      $error("settle and rate counts must lie in 1..65535");
   end

   localparam logic [15:0] SETTLE_M1 = 16'(SETTLE_CYCLES - 1);
   localparam logic [15:0] RATE_M1   = 16'(RATE_CYCLES - 1);

   // ***********************************************************
   // control register and mode field
   // ***********************************************************
   logic [15:0] ctrl;
   logic [3:0]  mode;
   logic        mode_wr;
   logic        diag_en;
   logic [3:0]  circ_en;
   logic        diag_clk_ok;
   amc_state_t  state;
   logic [15:0] cnt;
   logic        conv_done;

   assign mode      = ctrl[`AMC_MODE_MSB:`AMC_MODE_LSB];
   assign mode_wr   = i_ctrl_we;
   // a mode write in the same cycle abandons the result that would have landed
   assign conv_done = (state == AMC_ST_RUN) && i_sample_valid && (cnt == 16'h0000)
                      && !mode_wr;

   // control register; kept through power-down, changed by host writes and by single mode falling to standby
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         ctrl <= `AMC_CTRL_RESET;
      else if (i_ctrl_we)
         ctrl <= i_ctrl_wdata;
      else if (state == AMC_ST_HOLD && mode == `AMC_MODE_SINGLE)
         ctrl <= {ctrl[15:`AMC_MODE_MSB+1], `AMC_MODE_STANDBY, ctrl[`AMC_MODE_LSB-1:0]};
   end

   // diagnostic and circuit enables stay writable in every mode but power-down
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         diag_en     <= 1'b0;
         circ_en     <= 4'h0;
         diag_clk_ok <= 1'b0;
      end
      else if (mode == `AMC_MODE_PDOWN && !i_ctrl_we)
      begin
         diag_en     <= 1'b0;
         circ_en     <= 4'h0;
         diag_clk_ok <= 1'b0;
      end
      else if (i_diag_we)
      begin
         diag_en     <= i_diag_en;
         circ_en     <= i_circ_en;
         // clock-based checks only take hold when enabled in continuous or idle mode
         diag_clk_ok <= i_diag_en && (mode == `AMC_MODE_CONT || mode == `AMC_MODE_IDLE);
      end
   end

   // ***********************************************************
   // conversion sequencer
   // ***********************************************************
   // a mode write restarts settling for continuous or single and stops the sequencer otherwise, so no stale filter state leaks out
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         state <= AMC_ST_SETTLE;
         cnt   <= SETTLE_M1;
      end
      else if (mode_wr)
      begin
         unique case (i_ctrl_wdata[`AMC_MODE_MSB:`AMC_MODE_LSB])
            `AMC_MODE_CONT, `AMC_MODE_SINGLE:
            begin
               state <= AMC_ST_SETTLE;
               cnt   <= SETTLE_M1;
            end
            default:
            begin
               state <= AMC_ST_OFF;
               cnt   <= 16'h0000;
            end
         endcase
      end
      else
      begin
         unique case (state)
            AMC_ST_OFF:
            begin
               state <= AMC_ST_OFF;
            end
            AMC_ST_SETTLE:
            begin
               if (cnt != 16'h0000)
                  cnt <= cnt - 16'h0001;
               else
               begin
                  state <= AMC_ST_RUN;
               end
            end
            AMC_ST_RUN:
            begin
               if (cnt != 16'h0000)
                  cnt <= cnt - 16'h0001;
               else if (i_sample_valid)
               begin
                  if (mode == `AMC_MODE_SINGLE)
                     state <= AMC_ST_HOLD;
                  else
                     cnt <= RATE_M1;
               end
            end
            AMC_ST_HOLD:
            begin
               state <= AMC_ST_OFF;
            end
         endcase
      end
   end

   // ***********************************************************
   // data register and ready indication
   // ***********************************************************
   // result kept until overwritten; only power-down loses it
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         o_data <= `AMC_DATA_RESET;
      else if (conv_done)
         o_data <= i_sample;
      else if (mode == `AMC_MODE_PDOWN)
         o_data <= `AMC_DATA_RESET;
   end

   // completion wins over a read finishing in the same cycle
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         o_ready_n <= 1'b1;
      else if (conv_done)
         o_ready_n <= 1'b0;
      else if (i_data_read_done || mode_wr)
         o_ready_n <= 1'b1;
   end

   // shift request: automatic with continuous read, else on host command
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         o_shift_out <= 1'b0;
      else
         o_shift_out <= (conv_done && i_cont_read) || (i_read_cmd && !i_cont_read);
   end

   // ***********************************************************
   // power controls
   // ***********************************************************
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_power <= '{regs_on: 1'b1, osc_on: 1'b1, mod_on: 1'b1, default: 1'b0};
         o_ctrl  <= `AMC_CTRL_RESET;
         o_mode  <= `AMC_MODE_RESET;
      end
      else
      begin
         o_ctrl              <= ctrl;
         o_mode              <= mode;
         o_power.regs_on     <= (mode != `AMC_MODE_PDOWN);
         o_power.ref_on      <= (mode != `AMC_MODE_PDOWN) && circ_en[0];
         o_power.osc_on      <= (mode != `AMC_MODE_PDOWN) && (circ_en[1] || mode != `AMC_MODE_STANDBY);
         o_power.lsw_on      <= (mode != `AMC_MODE_PDOWN) && circ_en[2];
         o_power.bias_on     <= (mode != `AMC_MODE_PDOWN) && circ_en[3];
         o_power.mod_on      <= (mode == `AMC_MODE_CONT || mode == `AMC_MODE_SINGLE
                                 || mode == `AMC_MODE_IDLE);
         o_power.mod_reset   <= (mode == `AMC_MODE_IDLE);
         o_power.diag_on     <= diag_en && (mode != `AMC_MODE_PDOWN);
         o_power.clk_diag_on <= diag_clk_ok && (mode == `AMC_MODE_CONT
                                 || mode == `AMC_MODE_IDLE || mode == `AMC_MODE_SINGLE);
      end
   end

   // ***********************************************************
   // assertions
   // ***********************************************************
   // cycles since the last restart; saturates rather than wrapping
   logic [15:0] since_start;
   logic [15:0] since_result;
   always_ff @(posedge i_clock)
   begin
      if (i_rst || mode_wr)
         since_start <= 16'h0000;
      else if (since_start != 16'hFFFF)
         since_start <= since_start + 16'h0001;
   end

   // cycles since the last accepted result or restart
   always_ff @(posedge i_clock)
   begin
      if (i_rst || mode_wr || conv_done)
         since_result <= 16'h0000;
      else if (since_result != 16'hFFFF)
         since_result <= since_result + 16'h0001;
   end

   settle_time_a: assert property (@(posedge i_clock) disable iff (i_rst)
      conv_done && since_result == since_start |-> since_start >= SETTLE_CYCLES)
      else $error("first result before settling ended");
   rate_gap_a: assert property (@(posedge i_clock) disable iff (i_rst)
      conv_done && since_result != since_start |-> since_result >= RATE_M1)
      else $error("results closer than the output rate");
   ready_low_done_a: assert property (@(posedge i_clock) disable iff (i_rst)
      conv_done |=> !o_ready_n) else $error("ready not low after completion");
   ready_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
      i_data_read_done && !conv_done |=> o_ready_n) else $error("ready not released");
   settle_restart_a: assert property (@(posedge i_clock) disable iff (i_rst)
      mode_wr |=> !conv_done) else $error("result right after mode write");
   single_standby_a: assert property (@(posedge i_clock) disable iff (i_rst)
      conv_done && mode == `AMC_MODE_SINGLE ##1 !mode_wr |=> mode == `AMC_MODE_STANDBY)
      else $error("single did not fall to standby");
   pdown_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
      mode == `AMC_MODE_PDOWN |=> !o_power.regs_on && !o_power.bias_on)
      else $error("power-down left circuits on");
   idle_reset_a: assert property (@(posedge i_clock) disable iff (i_rst)
      mode == `AMC_MODE_IDLE |=> o_power.mod_reset && o_power.mod_on)
      else $error("idle not holding modulator reset");
   data_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
      !conv_done && mode == `AMC_MODE_STANDBY |=> $stable(o_data))
      else $error("data changed in standby");
   stby_clkdiag_a: assert property (@(posedge i_clock) disable iff (i_rst)
      mode == `AMC_MODE_STANDBY |=> !o_power.clk_diag_on)
      else $error("clock diagnostics in standby");
   mode_field_a: assert property (@(posedge i_clock) disable iff (i_rst)
      i_ctrl_we |=> mode == $past(i_ctrl_wdata[`AMC_MODE_MSB:`AMC_MODE_LSB]))
      else $error("mode field misplaced");
endmodule

// ===== hw/amc_defines.svh
// timing counts, field positions, mode codes and reset values for the mode controller
// assumes a 100 MHz system clock; included by bare name
`ifndef AMC_DEFINES_SVH
`define AMC_DEFINES_SVH
`define AMC_MODE_LSB        2
`define AMC_MODE_MSB        5
`define AMC_MODE_CONT       4'h0
`define AMC_MODE_SINGLE     4'h1
`define AMC_MODE_STANDBY    4'h2
`define AMC_MODE_PDOWN      4'h3
`define AMC_MODE_IDLE       4'h4
`define AMC_MODE_RESET      4'h0
`define AMC_CTRL_RESET      16'h0000
`define AMC_DATA_RESET      24'h000000
`define AMC_SETTLE_DEFAULT  32
`define AMC_RATE_DEFAULT    8
`endif

// ===== hw/amc_pkg.sv
// types shared by the mode controller and its bench
// assumes amc_defines.svh is on the include path
package amc_pkg;
   typedef enum logic [1:0] {AMC_ST_OFF, AMC_ST_SETTLE, AMC_ST_RUN, AMC_ST_HOLD} amc_state_t;
   // power and diagnostic controls presented to the analog side
   typedef struct packed {
      logic regs_on;
      logic ref_on;
      logic osc_on;
      logic lsw_on;
      logic bias_on;
      logic mod_on;
      logic mod_reset;
      logic clk_diag_on;
      logic diag_on;
   } amc_power_t;
endpackage

// ===== verification/amc_mod_model.sv
// modulator and filter model feeding results into the mode controller
// assumes the bench clock; the bench supplies the result word and a run level
`timescale 1ns/1ps
module amc_mod_model (
   input  wire logic        i_clock,
   input  wire logic        i_run,
   input  wire logic [23:0] i_word,
   output logic             o_valid,
   output logic [23:0]      o_sample
);
   // ****************************************
   // result pacing
   // ****************************************
   logic [1:0] cnt = 2'h0;
   initial
   begin
      o_valid  = 1'b0;
      o_sample = 24'h000000;
   end
   // one result every third cycle; between pulses the word is inverted
   // so a stale sample can never pass for a fresh one
   always @(negedge i_clock)
   begin
      cnt      <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
      o_valid  <= i_run && (cnt == 2'h2);
      o_sample <= (i_run && (cnt == 2'h2)) ? i_word : ~i_word;
   end
endmodule

// ===== verification/test_amc_mode_ctrl.sv
// self-checking bench of the operating-mode controller
// assumes amc_pkg is compiled first and amc_defines.svh is on the include path
`timescale 1ns/1ps
`include "amc_defines.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module test_amc_mode_ctrl
   import amc_pkg::*;
;
   // ****************************************
   // stimulus and design
   // ****************************************
   logic        i_clock = 1'b0, i_rst = 1'b1, i_ctrl_we = 1'b0, i_diag_we = 1'b0;
   logic        i_diag_en = 1'b0, i_cont_read = 1'b0, i_read_cmd = 1'b0;
   logic        i_data_read_done = 1'b0, i_sample_valid;
   logic [3:0]  i_circ_en = 4'h0;
   logic [15:0] i_ctrl_wdata = 16'h0000, o_ctrl;
   logic [23:0] i_sample, o_data, word = 24'hA5C31E;
   logic        o_ready_n, o_shift_out, seen;
   logic [3:0]  o_mode;
   amc_power_t  o_power;
   int          n_errors = 0, n_compared = 0, cycles = 0;
   always #5 i_clock = ~i_clock;
   // rate longer than the model's pacing, so some offered results are refused
   amc_mode_ctrl #(.SETTLE_CYCLES(2), .RATE_CYCLES(4)) i_amc_mode_ctrl (
      .i_clock(i_clock), .i_rst(i_rst), .i_ctrl_we(i_ctrl_we), .i_ctrl_wdata(i_ctrl_wdata),
      .i_diag_we(i_diag_we), .i_diag_en(i_diag_en), .i_circ_en(i_circ_en),
      .i_cont_read(i_cont_read), .i_read_cmd(i_read_cmd), .i_data_read_done(i_data_read_done),
      .i_sample_valid(i_sample_valid), .i_sample(i_sample), .o_ctrl(o_ctrl), .o_data(o_data),
      .o_ready_n(o_ready_n), .o_shift_out(o_shift_out), .o_mode(o_mode), .o_power(o_power));
   amc_mod_model i_amc_mod_model (.i_clock(i_clock), .i_run(1'b1), .i_word(word),
      .o_valid(i_sample_valid), .o_sample(i_sample));
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // a hung wait lands here instead of running forever
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         test_done();
      end
   end
   task automatic wr_ctrl(input logic [15:0] v);
      i_ctrl_wdata = v;
      i_ctrl_we    = 1'b1;
      @(negedge i_clock) i_ctrl_we = 1'b0;
   endtask
   task automatic wr_diag(input logic en, input logic [3:0] circ);
      {i_diag_en, i_circ_en} = {en, circ};
      i_diag_we = 1'b1;
      @(negedge i_clock) i_diag_we = 1'b0;
   endtask
   // waits for ready low, noting any shift-out pulse on the way
   task automatic wait_rdy();
      seen = 1'b0;
      for (int k = 0; k < 40 && o_ready_n !== 1'b0; k++)
      begin
         @(negedge i_clock);
         seen |= (o_shift_out === 1'b1);
      end
      `CHK(o_ready_n, 1'b0)
   endtask
   task automatic rd_done();
      i_data_read_done = 1'b1;
      @(negedge i_clock) i_data_read_done = 1'b0;
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial
   begin
      repeat (5) @(negedge i_clock);
      i_rst = 1'b0;
      `CHK({o_ctrl, o_mode, o_data, o_ready_n}, {16'h0000, 4'h0, 24'h0, 1'b1})
      @(negedge i_clock);
      `CHK(o_ready_n, 1'b1)
      wait_rdy();
      `CHK(o_data, word)
      rd_done();
      `CHK(o_ready_n, 1'b1)
      word = 24'h3C0F96;
      wait_rdy();
      `CHK(o_data, word)
      // continuous read: result shifts out as ready falls
      rd_done();
      i_cont_read = 1'b1;
      wait_rdy();
      `CHK(seen, 1'b1)
      i_cont_read = 1'b0;
      i_read_cmd  = 1'b1;
      @(negedge i_clock) i_read_cmd = 1'b0;
      seen = o_shift_out;
      @(negedge i_clock) seen |= o_shift_out;
      `CHK(seen, 1'b1)
      // other control bits set around a zero mode field
      wr_ctrl(16'hFFC3);
      `CHK(o_ready_n, 1'b1)
      @(negedge i_clock);
      `CHK({o_ctrl, o_mode, o_ready_n}, {16'hFFC3, 4'h0, 1'b1})
      word = 24'h00F00D;
      wr_ctrl({10'h000, `AMC_MODE_SINGLE, 2'h0});
      wait_rdy();
      `CHK(o_data, 24'h00F00D)
      word = 24'h777777;
      repeat (8) @(negedge i_clock);
      `CHK({o_mode, o_data, o_ready_n}, {`AMC_MODE_STANDBY, 24'h00F00D, 1'b0})
      wr_diag(1'b1, 4'hF);
      @(negedge i_clock);
      `CHK({o_power.regs_on, o_power.ref_on, o_power.osc_on}, 3'h7)
      `CHK({o_power.lsw_on, o_power.bias_on, o_power.diag_on}, 3'h7)
      `CHK({o_power.clk_diag_on, o_data}, {1'b0, 24'h00F00D})
      rd_done();
      `CHK(o_ready_n, 1'b1)
      // standby with every circuit disabled leaves only the regulators and the diagnostics on
      wr_diag(1'b1, 4'h0);
      @(negedge i_clock);
      `CHK({o_power.regs_on, o_power.ref_on, o_power.osc_on, o_power.bias_on}, 4'h8)
      wr_ctrl({10'h000, `AMC_MODE_IDLE, 2'h0});
      wr_diag(1'b1, 4'h0);
      @(negedge i_clock);
      `CHK({o_power.mod_reset, o_power.clk_diag_on, o_ready_n}, 3'h7)
      // a reserved mode code stops the converter outright
      wr_ctrl({10'h000, 4'h9, 2'h0});
      @(negedge i_clock);
      `CHK({o_power.mod_on, o_power.mod_reset, o_ready_n}, 3'h1)
      wr_ctrl({10'h000, `AMC_MODE_PDOWN, 2'h0});
      repeat (3) @(negedge i_clock);
      `CHK({o_power.regs_on, o_power.osc_on, o_power.bias_on, o_power.mod_on}, 4'h0)
      `CHK({o_power.ref_on, o_power.lsw_on, o_power.diag_on, o_data}, 27'h0)
      // leaving power-down the host programs every setting again
      wr_ctrl({10'h000, `AMC_MODE_CONT, 2'h0});
      wr_diag(1'b0, 4'h0);
      wait_rdy();
      `CHK(o_data, 24'h777777)
      test_done();
   end
endmodule
